//--- common/lcdra_pkg.sv
// Constants and types shared by the character LCD addressing core.
// Assumes a single 100 MHz ref_clk domain and a synchronous active-low reset.
package lcdra_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Memory geometry and address spans.
    localparam int          CELL_COUNT    = 14;
    localparam logic [7:0]  DISP_FIRST    = 8'h00;
    localparam logic [7:0]  DISP_LAST     = 8'h0D;
    localparam logic [7:0]  ICON_FIRST    = 8'h10;
    localparam logic [7:0]  ICON_LAST     = 8'h1D;
    localparam logic [7:0]  USER_CODE_TOP = 8'h1F;
    localparam logic [2:0]  ROW_LAST      = 3'h6;
    localparam logic [3:0]  POS_LAST      = 4'hD;
    localparam logic [4:0]  CELL_MOD      = 5'h0E;
    localparam logic [3:0]  SHIFT_LEFT    = 4'h1;
    localparam logic [3:0]  SHIFT_RIGHT   = 4'hD;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction encodings written through the instruction holding register.
    localparam logic [7:0]  INS_CLEAR     = 8'h01;
    localparam logic [7:0]  INS_HOME      = 8'h02;
    localparam logic [6:0]  INS_ENTRY_PFX = 7'h02;
    localparam logic [6:0]  INS_SHIFT_PFX = 7'h08;
    localparam int          INS_ADDR_BIT  = 7;
    localparam int          INS_USER_BIT  = 6;
    localparam logic [7:0]  BLANK_CODE    = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [3:0]  RST_SHIFT     = 4'h0;
    localparam logic        RST_INCR      = 1'b1;

    // Memory that data accesses are steered to.
    typedef enum logic [1:0]
    {
        SEL_DISP = 2'b00,
        SEL_USER = 2'b01,
        SEL_ICON = 2'b10
    } lcdra_ram_sel_type;

endpackage : lcdra_pkg

//--- tb/lcdra_core_sva.sv
// Checker for the port behaviour of the addressing core.
// Assumes it is bound to lcdra_core and sees only its ports.
module lcdra_core_sva
(
    // Clock and reset.
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // Host byte port.
    input wire logic       host_write,
    input wire logic       host_read,
    input wire logic       register_select_line,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic       transfer_busy,
    input wire logic [7:0] ram_address_counter,
    // Refresh stream.
    input wire logic [3:0] seg_position,
    input wire logic [2:0] seg_row
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Host transfer steps.
    sequence data_wr;
        host_write && register_select_line;
    endsequence
    sequence ins_wr;
        host_write && !register_select_line;
    endsequence
    sequence quiet2;
        (!host_write && !host_read) [*2];
    endsequence

    a_busy_after_write: assert property (data_wr |=> transfer_busy)
        else $error("busy missing after data write");
    a_busy_only_write: assert property
        (!(host_write && register_select_line) |=> !transfer_busy)
        else $error("busy without data write");
    a_rdata_takes_byte: assert property
        (data_wr |=> host_rdata == $past(host_wdata))
        else $error("data register missed byte");
    a_ins_keeps_rdata: assert property (ins_wr |=> $stable(host_rdata))
        else $error("instruction altered data register");
    a_set_disp_addr: assert property
        (ins_wr ##0 host_wdata[7] |=> ram_address_counter == {1'b0, $past(host_wdata[6:0])})
        else $error("address set not loaded");
    a_set_user_addr: assert property
        (ins_wr ##0 host_wdata[7:6] == 2'b01
            |=> ram_address_counter == {$past(host_wdata[5:0]), 2'b00})
        else $error("user font address not loaded");
    a_counter_holds: assert property (quiet2 |=> $stable(ram_address_counter))
        else $error("counter moved without access");
    a_counter_steps: assert property
        (data_wr ##1 (!host_write && !host_read)
            |=> ram_address_counter != $past(ram_address_counter, 2))
        else $error("counter did not step");
    a_scan_wraps: assert property (seg_position == 4'hD |=> seg_position == 4'h0)
        else $error("scan did not wrap");
    a_scan_advances: assert property
        ($past(rst_n, 2) && seg_position != 4'hD |=> seg_position == $past(seg_position) + 4'h1)
        else $error("scan did not advance");
    a_row_advances: assert property
        (seg_position == 4'hD
            |=> seg_row == (($past(seg_row) == 3'h6) ? 3'h0 : $past(seg_row) + 3'h1))
        else $error("row did not advance");
endmodule : lcdra_core_sva

bind lcdra_core lcdra_core_sva chk_u
(
    .ref_clk, .rst_n, .host_write, .host_read, .register_select_line, .host_wdata,
    .host_rdata, .transfer_busy, .ram_address_counter, .seg_position, .seg_row
);

//--- tb/lcdra_host_model.sv
// Host model that drives the byte port of the addressing core.
// Assumes a free-running ref_clk; it drives on the falling edge only.
module lcdra_host_model
(
    // Clock.
    input  wire logic       ref_clk,
    // Byte port toward the core.
    output      logic       host_write,
    output      logic       host_read,
    output      logic       register_select_line,
    output      logic [7:0] host_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels from time zero.
    initial
    begin
        host_write = 1'b0;
        host_read = 1'b0;
        register_select_line = 1'b0;
        host_wdata = 8'hA5;
    end

    // One write strobe, then an idle cycle with the data bus scrambled.
    task automatic send(input logic sel, input logic [7:0] data);
        @(negedge ref_clk);
        register_select_line = sel;
        host_wdata = data;
        host_write = 1'b1;
        @(negedge ref_clk);
        host_write = 1'b0;
        host_wdata = ~data;
    endtask : send

    // One read strobe with the given select level.
    task automatic fetch(input logic sel);
        @(negedge ref_clk);
        register_select_line = sel;
        host_read = 1'b1;
        @(negedge ref_clk);
        host_read = 1'b0;
    endtask : fetch

    // Two data writes on consecutive edges, the second one landing in the busy cycle.
    task automatic burst(input logic [7:0] d0, input logic [7:0] d1);
        @(negedge ref_clk);
        register_select_line = 1'b1;
        host_wdata = d0;
        host_write = 1'b1;
        @(negedge ref_clk);
        host_wdata = d1;
        @(negedge ref_clk);
        host_write = 1'b0;
        host_wdata = ~d1;
    endtask : burst
endmodule : lcdra_host_model

//--- tb/tb.sv
// Self-checking bench for the addressing core with a host model.
// Assumes a 100 MHz clock and the host model's falling-edge drive.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic host_write, host_read, register_select_line, transfer_busy;
    logic [7:0] host_wdata, host_rdata, ram_address_counter;
    logic [3:0] seg_position;
    logic [2:0] seg_row;
    logic [4:0] seg_dots;
    logic [4:0] font [256];
    logic [7:0] code [14];
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed;

    // Clock and instances.
    always #5 ref_clk = ~ref_clk;
    lcdra_core dut_u (.ref_clk, .rst_n, .host_write, .host_read, .register_select_line,
        .host_wdata, .host_rdata, .transfer_busy, .ram_address_counter, .seg_position,
        .seg_row, .seg_dots);
    lcdra_host_model host_u (.ref_clk, .host_write, .host_read, .register_select_line,
        .host_wdata);

    // Compares and counts.
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Dots expected at a cell and row for a given rotation.
    function automatic logic [4:0] shown(input logic [3:0] pos, input logic [2:0] row,
                                         input int sh);
        return font[{code[(pos + sh) % 14][4:0], row}];
    endfunction : shown

    // Sets a rotation from home, then checks one whole refresh frame.
    task automatic scan(input logic [7:0] ins, input int sh);
        host_u.send(1'b0, 8'h02);
        if (ins != 8'h02) host_u.send(1'b0, ins);
        repeat (3) @(negedge ref_clk);
        repeat (98)
        begin
            @(negedge ref_clk);
            check({3'h0, seg_dots}, {3'h0, shown(seg_position, seg_row, sh)}, "dots");
        end
    endtask : scan

    // Final report and end of run.
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // Cuts a hang short.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // Main sequence.
    initial
    begin
        seed = $urandom(32'hFFD3E9EE);
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check(host_rdata, 8'h00, "rdata reset");
        check(ram_address_counter, 8'h00, "counter reset");
        check({7'h0, transfer_busy}, 8'h00, "busy reset");
        host_u.send(1'b0, 8'h40);
        for (int i = 0; i < 256; i++)
        begin
            font[i] = 5'($urandom());
            host_u.send(1'b1, {3'h0, font[i]});
        end
        @(negedge ref_clk);
        check(ram_address_counter, 8'h00, "user font wrap");
        host_u.send(1'b0, 8'h80);
        for (int i = 0; i < 14; i++)
        begin
            code[i] = 8'($urandom_range(31));
            host_u.send(1'b1, code[i]);
        end
        @(negedge ref_clk);
        check(ram_address_counter, 8'h00, "display wrap");
        host_u.send(1'b0, 8'h9D);
        check(ram_address_counter, 8'h1D, "icon address");
        host_u.send(1'b1, 8'h1F);
        @(negedge ref_clk);
        check(ram_address_counter, 8'h10, "icon wrap");
        host_u.send(1'b0, 8'h9D);
        host_u.fetch(1'b1);
        check(host_rdata, 8'h1F, "icon read back");
        check(ram_address_counter, 8'h10, "icon read wrap");
        host_u.send(1'b0, 8'h83);
        host_u.fetch(1'b1);
        check(host_rdata, code[3], "read data");
        check(ram_address_counter, 8'h04, "read step");
        host_u.fetch(1'b0);
        check(ram_address_counter, 8'h04, "refused read");
        host_u.send(1'b0, 8'h04);
        host_u.send(1'b0, 8'h85);
        host_u.fetch(1'b1);
        check(ram_address_counter, 8'h04, "read decrement");
        code[4] = code[5];
        host_u.send(1'b1, code[5]);
        check(host_rdata, code[5], "data register");
        @(negedge ref_clk);
        check(ram_address_counter, 8'h03, "write decrement");
        code[3] = 8'($urandom_range(31));
        code[2] = 8'($urandom_range(31));
        host_u.burst(code[3], code[2]);
        @(negedge ref_clk);
        check(ram_address_counter, 8'h01, "burst step");
        host_u.send(1'b0, 8'h05);
        scan(8'h02, 0);
        scan(8'h10, 1);
        scan(8'h11, 13);
        host_u.send(1'b0, 8'h87);
        host_u.send(1'b0, 8'h01);
        check(ram_address_counter, 8'h00, "clear");
        host_u.fetch(1'b1);
        check(host_rdata, lcdra_pkg::BLANK_CODE, "clear fill");
        test_done();
    end
endmodule : tb

//--- verilog/lcdra_core.sv
// Addressing core of a 14-cell single-line character LCD controller.
// Assumes host strobes come from a serial front end on ref_clk, so they are
// not resynchronised; strobes may come on consecutive cycles, including a data write in the busy cycle.

module lcdra_core
(
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Host byte port.
    input  wire logic       host_write,
    input  wire logic       host_read,
    input  wire logic       register_select_line,
    input  wire logic [7:0] host_wdata,
    output      logic [7:0] host_rdata,
    output      logic       transfer_busy,
    // Address state seen by software.
    output      logic [7:0] ram_address_counter,
    // Refresh stream toward the segment drivers.
    output      logic [3:0] seg_position,
    output      logic [2:0] seg_row,
    output      logic [4:0] seg_dots
);

    // Complete state of the core.
    typedef struct packed
    {
        logic [7:0]                  instruction_holding;
        logic [7:0]                  data_holding;
        logic [7:0]                  ac;
        lcdra_pkg::lcdra_ram_sel_type sel;
        logic                        incr;
        logic [3:0]                  shift;
        logic                        pending;
        logic [13:0][7:0]            display_char_ram;
        logic [255:0][4:0]           user_font_ram;
        logic [13:0][4:0]            icon_ram;
        logic [3:0]                  scan_pos;
        logic [2:0]                  scan_row;
        logic [3:0]                  out_pos;
        logic [2:0]                  out_row;
        logic [4:0]                  out_dots;
    } lcdra_state_type;

    lcdra_state_type state;
    lcdra_state_type next_state;
    logic [4:0]      scan_sum;
    logic [3:0]      scan_addr;
    logic [7:0]      scan_code;
    logic [4:0]      scan_user_row;
    logic [4:0]      font_dots;

    // Step an address inside the span of the selected memory, wrapping at its ends.
    function automatic logic [7:0] step_addr(input logic [7:0] addr,
                                             input lcdra_pkg::lcdra_ram_sel_type sel,
                                             input logic incr);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = (sel == lcdra_pkg::SEL_ICON) ? lcdra_pkg::ICON_FIRST : lcdra_pkg::DISP_FIRST;
        hi = (sel == lcdra_pkg::SEL_ICON) ? lcdra_pkg::ICON_LAST : lcdra_pkg::DISP_LAST;
        if (sel == lcdra_pkg::SEL_USER)
            return incr ? 8'(addr + 8'h01) : 8'(addr - 8'h01);
        if (incr)
            return (addr >= hi) ? lo : 8'(addr + 8'h01);
        return (addr <= lo) ? hi : 8'(addr - 8'h01);
    endfunction : step_addr

    ////////////////////////////////////////////////////////////////////////////
    // Refresh side: map scan position through the shift and fetch the cell.
    always_comb
    begin
        scan_sum      = {1'b0, state.scan_pos} + {1'b0, state.shift};
        if (scan_sum >= lcdra_pkg::CELL_MOD)
            scan_sum = 5'(scan_sum - lcdra_pkg::CELL_MOD);
        scan_addr     = scan_sum[3:0];
        scan_code     = state.display_char_ram[scan_addr];
        scan_user_row = state.user_font_ram[{scan_code[4:0], state.scan_row}];
    end

    // Font lookup for the cell currently being scanned.
    lcdra_font u_font
    (
        .char_code (scan_code),
        .dot_row   (state.scan_row),
        .user_row  (scan_user_row),
        .dots      (font_dots)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state: automatic transfer, host access, then the refresh scan.
    always_comb
    begin
        next_state = state;

        // Move the held data byte into the selected memory, then step the counter.
        if (state.pending)
        begin
            unique case (state.sel)
                lcdra_pkg::SEL_DISP: next_state.display_char_ram[state.ac[3:0]] =
                    state.data_holding;
                lcdra_pkg::SEL_USER: next_state.user_font_ram[state.ac] =
                    state.data_holding[4:0];
                lcdra_pkg::SEL_ICON: next_state.icon_ram[4'(state.ac - lcdra_pkg::ICON_FIRST)] =
                    state.data_holding[4:0];
                default: next_state.pending = 1'b0;
            endcase
            next_state.ac      = step_addr(state.ac, state.sel, state.incr);
            next_state.pending = 1'b0;
        end

        // Host writes land in one of the two holding registers.
        if (host_write && register_select_line)
        begin
            next_state.data_holding = host_wdata;
            next_state.pending      = 1'b1;
        end
        else if (host_write)
        begin
            next_state.instruction_holding = host_wdata;
            if (host_wdata[lcdra_pkg::INS_ADDR_BIT])
            begin
                next_state.ac  = {1'b0, host_wdata[6:0]};
                next_state.sel = (host_wdata[6:0] >= lcdra_pkg::ICON_FIRST[6:0])
                    ? lcdra_pkg::SEL_ICON : lcdra_pkg::SEL_DISP;
            end
            else if (host_wdata[lcdra_pkg::INS_USER_BIT])
            begin
                next_state.ac  = {host_wdata[5:0], 2'b00};
                next_state.sel = lcdra_pkg::SEL_USER;
            end
            else if (host_wdata[7:1] == lcdra_pkg::INS_SHIFT_PFX)
            begin
                if (host_wdata[0])
                    next_state.shift = (state.shift == lcdra_pkg::RST_SHIFT)
                        ? lcdra_pkg::SHIFT_RIGHT : 4'(state.shift - 4'h1);
                else
                    next_state.shift = (state.shift == lcdra_pkg::POS_LAST)
                        ? lcdra_pkg::RST_SHIFT : 4'(state.shift + lcdra_pkg::SHIFT_LEFT);
            end
            else if (host_wdata[7:1] == lcdra_pkg::INS_ENTRY_PFX)
                next_state.incr = host_wdata[0];
            else if (host_wdata == lcdra_pkg::INS_HOME || host_wdata == lcdra_pkg::INS_CLEAR)
            begin
                next_state.ac    = lcdra_pkg::DISP_FIRST;
                next_state.sel   = lcdra_pkg::SEL_DISP;
                next_state.shift = lcdra_pkg::RST_SHIFT;
                if (host_wdata == lcdra_pkg::INS_CLEAR)
                    next_state.display_char_ram = {lcdra_pkg::CELL_COUNT{lcdra_pkg::BLANK_CODE}};
            end
        end
        else if (host_read && register_select_line)
        begin
            // Reads fetch the addressed byte into the data register and step the counter.
            unique case (next_state.sel)
                lcdra_pkg::SEL_DISP: next_state.data_holding =
                    next_state.display_char_ram[next_state.ac[3:0]];
                lcdra_pkg::SEL_USER: next_state.data_holding =
                    {3'h0, next_state.user_font_ram[next_state.ac]};
                lcdra_pkg::SEL_ICON: next_state.data_holding =
                    {3'h0, next_state.icon_ram[4'(next_state.ac - lcdra_pkg::ICON_FIRST)]};
                default: next_state.data_holding = lcdra_pkg::RST_BYTE;
            endcase
            next_state.ac = step_addr(next_state.ac, next_state.sel, next_state.incr);
        end

        // The scan runs on its own counters and only ever reads memory.
        next_state.out_pos  = state.scan_pos;
        next_state.out_row  = state.scan_row;
        next_state.out_dots = font_dots;
        if (state.scan_pos == lcdra_pkg::POS_LAST)
        begin
            next_state.scan_pos = 4'h0;
            next_state.scan_row = (state.scan_row == lcdra_pkg::ROW_LAST)
                ? 3'h0 : 3'(state.scan_row + 3'h1);
        end
        else
            next_state.scan_pos = 4'(state.scan_pos + 4'h1);

        // Synchronous reset clears control state except incr, which is set; memory contents are left alone.
        if (!rst_n)
        begin
            next_state.instruction_holding = lcdra_pkg::RST_BYTE;
            next_state.data_holding        = lcdra_pkg::RST_BYTE;
            next_state.ac                  = lcdra_pkg::DISP_FIRST;
            next_state.sel                 = lcdra_pkg::SEL_DISP;
            next_state.incr                = lcdra_pkg::RST_INCR;
            next_state.shift               = lcdra_pkg::RST_SHIFT;
            next_state.pending             = 1'b0;
            next_state.scan_pos            = 4'h0;
            next_state.scan_row            = 3'h0;
            next_state.out_pos             = 4'h0;
            next_state.out_row             = 3'h0;
            next_state.out_dots            = 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge ref_clk)
    begin
        state <= next_state;
    end

    // Outputs straight from the state register.
    assign host_rdata          = state.data_holding;
    assign transfer_busy       = state.pending;
    assign ram_address_counter = state.ac;
    assign seg_position        = state.out_pos;
    assign seg_row             = state.out_row;
    assign seg_dots            = state.out_dots;

endmodule : lcdra_core

//--- verilog/lcdra_font.sv
// Character code to dot row decoder for one character cell.
// Assumes the caller supplies the user font row already read for this code.
module lcdra_font
(
    // Character being decoded.
    input  wire logic [7:0] char_code,
    input  wire logic [2:0] dot_row,
    // Row fetched from the user font memory.
    input  wire logic [4:0] user_row,
    // Resulting dots, bit 4 leftmost.
    output      logic [4:0] dots
);

    // Fixed glyph generator for codes 20 to FF; a stand-in until a mask table is fitted.
    function automatic logic [4:0] fixed_font_rom(input logic [7:0] code, input logic [2:0] row);
        logic [7:0] mix;
        mix = code ^ {row, row, row[1:0]};
        return (row == 3'h0) ? 5'h00 : mix[4:0];
    endfunction : fixed_font_rom

    ////////////////////////////////////////////////////////////////////////////
    // Low codes pick the user patterns, all others the fixed glyphs.
    always_comb
    begin
        if (char_code <= lcdra_pkg::USER_CODE_TOP)
            dots = user_row;
        else
            dots = fixed_font_rom(char_code, dot_row);
    end

endmodule : lcdra_font
